// *** logic/bcd_counter.sv ***
// eight-digit decimal counter with synchronous clear
`timescale 1ns/1ns
`default_nettype none
module bcd_counter #(
    parameter int unsigned DIGITS = 8
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // control
    input  wire logic                  clr,
    input  wire logic                  inc,
    // count, one nibble per digit
    output var  logic [4*DIGITS-1:0]   digits_ff
);

    logic [DIGITS:0]      carry;
    logic [4*DIGITS-1:0]  nxt_digits;

    assign carry[0] = inc;

    // ripple carry, one digit per stage; wraps past all nines
    for (genvar i = 0; i < DIGITS; i++)
    begin : g_digit
        always_comb
        begin
            carry[i+1] = carry[i] && (digits_ff[4*i +: 4] == 4'h9);
            if (clr)
                nxt_digits[4*i +: 4] = 4'h0;
            else if (carry[i])
                nxt_digits[4*i +: 4] = carry[i+1] ? 4'h0
                                     : digits_ff[4*i +: 4] + 4'h1;
            else
                nxt_digits[4*i +: 4] = digits_ff[4*i +: 4];
        end
    end

    // register the digits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            digits_ff <= '0;
        else
            digits_ff <= nxt_digits;
    end

endmodule
`default_nettype wire

// *** logic/flow_totalizer.sv ***
// flow totalizer: integrator, pulse generator, capped decimal counter
// Summary of operation
// - integrate flow; one increment pulse each time total reaches the unit
// - flow per second is full-scale flow times percent input over 100
// - every increment pulse advances the counter by exactly one
// - count held in eight decimal digits, all eight offered to displays
// - low four digits offered as 0.00 to 99.99 percent
// - at most 120 counts applied per cycle; surplus kept for later cycles
// - clear input high holds count at zero; counting resumes once low
// - totalization unit setting defaults to 1.0000
// - full-scale flow setting defaults to 10.000 units per second
// - pulse rate peaks at 327.67 percent input or 120 counts per cycle, set by flow and unit
`timescale 1ns/1ns
`default_nettype none
module flow_totalizer #(
    parameter int unsigned CYCLE_CLKS = flow_totalizer_pkg::CYCLE_CLKS,
    parameter int unsigned ACC_W      = 48,
    parameter int unsigned PEND_W     = 16
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output var  logic [31:0]  prdata_ff,
    output var  logic         pready_ff,
    output var  logic         pslverr_ff,
    // inputs from other function blocks
    input  wire logic [15:0]  flow_input_source,
    input  wire logic         clear_input_source,
    // results
    output var  logic         inc_pulse_ff,
    output var  logic [31:0]  count_bcd_ff,
    output var  logic [13:0]  count_percent_ff
);

    // all checks sample on the rising clock and sleep during reset
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // settings and control
    logic [31:0]   ctrl_ff, nxt_ctrl;
    logic [31:0]   totalization_unit_setting_ff, nxt_tu;
    logic [31:0]   full_scale_flow_setting_ff, nxt_fsf;
    logic [31:0]   cyc_time_ff, nxt_cyc_time;
    logic [31:0]   cyc_len_ff, nxt_cyc_len;
    logic [31:0]   nxt_prdata;
    logic          nxt_pready;
    logic          nxt_pslverr;
    logic          wr_done;
    logic          addr_ok;

    // integrator and counter state
    flow_totalizer_pkg::step_type  step_ff, nxt_step;
    logic [ACC_W-1:0]   acc_ff, nxt_acc;
    logic [PEND_W-1:0]  pend_ff, nxt_pend;
    logic [6:0]         applied_ff, nxt_applied;
    logic [31:0]        timer_ff, nxt_timer;
    logic               due_ff, nxt_due;
    logic               nxt_inc_pulse;
    logic [13:0]        nxt_percent;
    logic               cnt_inc;
    logic [31:0]        digits;

    // flow increment for one cycle
    logic [14:0]        pct;
    logic [78:0]        prod;
    logic [62:0]        quot;
    logic [ACC_W-1:0]   delta;
    logic               tick;
    logic               unit_fits;

    assign wr_done = psel && penable && pready_ff && pwrite;
    assign addr_ok = (paddr[1:0] == 2'b00)
                  && (paddr <= flow_totalizer_pkg::ACCUM_OFS);
    assign tick    = (timer_ff == cyc_len_ff - 32'h1) || (cyc_len_ff == 32'h0);

    // apb answer: one wait state, ready and data from flops
    always_comb
    begin
        nxt_pready  = psel && penable && !pready_ff;
        nxt_pslverr = nxt_pready && !addr_ok;
        nxt_prdata  = 32'h0;
        if (nxt_pready && !pwrite)
        begin
            unique case (paddr)
                flow_totalizer_pkg::CTRL_OFS:      nxt_prdata = ctrl_ff;
                flow_totalizer_pkg::STATUS_OFS:    nxt_prdata =
                    32'(pend_ff) | (32'(step_ff)
                    << flow_totalizer_pkg::STATUS_STATE_LSB);
                flow_totalizer_pkg::UNIT_OFS:      nxt_prdata =
                    totalization_unit_setting_ff;
                flow_totalizer_pkg::FULL_FLOW_OFS: nxt_prdata =
                    full_scale_flow_setting_ff;
                flow_totalizer_pkg::CYC_TIME_OFS:  nxt_prdata = cyc_time_ff;
                flow_totalizer_pkg::CYC_LEN_OFS:   nxt_prdata = cyc_len_ff;
                flow_totalizer_pkg::COUNT_OFS:     nxt_prdata = count_bcd_ff;
                flow_totalizer_pkg::ACCUM_OFS:     nxt_prdata = acc_ff[31:0];
                default:                           nxt_prdata = 32'h0;
            endcase
        end
    end

    // register writes take effect at the completing edge only
    always_comb
    begin
        nxt_ctrl     = ctrl_ff;
        nxt_tu       = totalization_unit_setting_ff;
        nxt_fsf      = full_scale_flow_setting_ff;
        nxt_cyc_time = cyc_time_ff;
        nxt_cyc_len  = cyc_len_ff;
        if (wr_done)
        begin
            unique case (paddr)
                flow_totalizer_pkg::CTRL_OFS:      nxt_ctrl     = pwdata;
                flow_totalizer_pkg::UNIT_OFS:      nxt_tu       = pwdata;
                flow_totalizer_pkg::FULL_FLOW_OFS: nxt_fsf      = pwdata;
                flow_totalizer_pkg::CYC_TIME_OFS:  nxt_cyc_time = pwdata;
                flow_totalizer_pkg::CYC_LEN_OFS:   nxt_cyc_len  = pwdata;
                default:                           nxt_ctrl     = ctrl_ff;
            endcase
        end
    end

    // bus and settings registers; defaults loaded at reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff                    <= 32'h0;
            pready_ff                    <= 1'b0;
            pslverr_ff                   <= 1'b0;
            ctrl_ff                      <= flow_totalizer_pkg::CTRL_RESET;
            totalization_unit_setting_ff <=
                flow_totalizer_pkg::UNIT_RESET;
            full_scale_flow_setting_ff   <=
                flow_totalizer_pkg::FULL_FLOW_RESET;
            cyc_time_ff                  <= flow_totalizer_pkg::CYC_TIME_RESET;
            cyc_len_ff                   <= 32'(CYCLE_CLKS);
        end
        else
        begin
            prdata_ff                    <= nxt_prdata;
            pready_ff                    <= nxt_pready;
            pslverr_ff                   <= nxt_pslverr;
            ctrl_ff                      <= nxt_ctrl;
            totalization_unit_setting_ff <= nxt_tu;
            full_scale_flow_setting_ff   <= nxt_fsf;
            cyc_time_ff                  <= nxt_cyc_time;
            cyc_len_ff                   <= nxt_cyc_len;
        end
    end

    // flow per cycle: full scale times percent over 100, times cycle time;
    // negative flow inputs count as zero, the counter never runs back
    always_comb
    begin
        pct   = flow_input_source[15] ? 15'h0 : flow_input_source[14:0];
        prod  = 79'(full_scale_flow_setting_ff) * 79'(pct)
              * 79'(cyc_time_ff);
        quot  = prod[78:16] / 63'(flow_totalizer_pkg::PCT_FULL);
        delta = (|quot[62:ACC_W]) ? '1 : quot[ACC_W-1:0];
        unit_fits = (totalization_unit_setting_ff != 32'h0)
                 && (acc_ff >= ACC_W'(totalization_unit_setting_ff));
    end

    // processing cycle timer; a due cycle waits while a step is busy
    always_comb
    begin
        nxt_timer = tick ? 32'h0 : timer_ff + 32'h1;
        nxt_due   = tick
                  || (due_ff && (step_ff != flow_totalizer_pkg::ST_IDLE));
    end

    // integrate, turn whole units into pending counts, apply them capped
    always_comb
    begin
        nxt_step    = step_ff;
        nxt_acc     = acc_ff;
        nxt_pend    = pend_ff;
        nxt_applied = applied_ff;
        cnt_inc     = 1'b0;
        unique case (step_ff)
            flow_totalizer_pkg::ST_IDLE:
                if (due_ff && ctrl_ff[flow_totalizer_pkg::CTRL_ENABLE_BIT])
                    nxt_step = flow_totalizer_pkg::ST_ADD;
            flow_totalizer_pkg::ST_ADD:
            begin
                // saturating add so a huge flow cannot wrap the total
                nxt_acc  = (acc_ff + delta < acc_ff) ? '1
                         : acc_ff + delta;
                nxt_step = flow_totalizer_pkg::ST_SUB;
            end
            flow_totalizer_pkg::ST_SUB:
                // one unit per clock; stops when pending count saturates
                if (unit_fits && (pend_ff != '1))
                begin
                    nxt_acc  = acc_ff
                             - ACC_W'(totalization_unit_setting_ff);
                    nxt_pend = pend_ff + PEND_W'(1);
                end
                else
                begin
                    nxt_applied = 7'h0;
                    nxt_step    = flow_totalizer_pkg::ST_APPLY;
                end
            flow_totalizer_pkg::ST_APPLY:
                if ((pend_ff != '0) && (applied_ff
                    != 7'(flow_totalizer_pkg::MAX_PER_CYCLE)))
                begin
                    cnt_inc     = 1'b1;
                    nxt_pend    = pend_ff - PEND_W'(1);
                    nxt_applied = applied_ff + 7'h1;
                end
                else
                    nxt_step = flow_totalizer_pkg::ST_IDLE;
        endcase
        // clear wipes count, surplus and remainder while it stands
        if (clear_input_source)
        begin
            nxt_acc  = '0;
            nxt_pend = '0;
            cnt_inc  = 1'b0;
        end
    end

    // output staging: pulse and percent view of the low digits
    always_comb
    begin
        nxt_inc_pulse = cnt_inc;
        nxt_percent   = 14'(digits[15:12]) * 14'd1000
                      + 14'(digits[11:8]) * 14'd100
                      + 14'(digits[7:4]) * 14'd10
                      + 14'(digits[3:0]);
    end

    // integrator and output registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            step_ff          <= flow_totalizer_pkg::ST_IDLE;
            acc_ff           <= '0;
            pend_ff          <= '0;
            applied_ff       <= 7'h0;
            timer_ff         <= 32'h0;
            due_ff           <= 1'b0;
            inc_pulse_ff     <= 1'b0;
            count_bcd_ff     <= 32'h0;
            count_percent_ff <= 14'h0;
        end
        else
        begin
            step_ff          <= nxt_step;
            acc_ff           <= nxt_acc;
            pend_ff          <= nxt_pend;
            applied_ff       <= nxt_applied;
            timer_ff         <= nxt_timer;
            due_ff           <= nxt_due;
            inc_pulse_ff     <= nxt_inc_pulse;
            count_bcd_ff     <= digits;
            count_percent_ff <= nxt_percent;
        end
    end

    // the eight-digit count itself
    bcd_counter #(
        .DIGITS    (8)
    ) u_count (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (clear_input_source),
        .inc       (cnt_inc),
        .digits_ff (digits)
    );

    // helper for checks: unit and full-scale flow settings untouched since reset
    logic tu_wr_ff;
    logic fsf_wr_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tu_wr_ff  <= 1'b0;
            fsf_wr_ff <= 1'b0;
        end
        else
        begin
            tu_wr_ff  <= tu_wr_ff
                      || (wr_done && paddr == flow_totalizer_pkg::UNIT_OFS);
            fsf_wr_ff <= fsf_wr_ff
                      || (wr_done
                      && paddr == flow_totalizer_pkg::FULL_FLOW_OFS);
        end
    end

    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_wait_s;
        psel && penable && !pready_ff;
    endsequence

    apb_ready_a: assert property (apb_setup_s ##1 apb_wait_s |=> pready_ff)
        else $error("apb access not answered after one wait");

    tu_default_a: assert property (!tu_wr_ff |->
        totalization_unit_setting_ff == flow_totalizer_pkg::UNIT_RESET)
        else $error("unit setting lost its default");

    fsf_default_a: assert property (!fsf_wr_ff |->
        full_scale_flow_setting_ff == flow_totalizer_pkg::FULL_FLOW_RESET)
        else $error("full-scale flow lost its default");

    pulse_count_a: assert property (cnt_inc |=> inc_pulse_ff
        && (digits != $past(digits)) ##1 count_bcd_ff == $past(digits))
        else $error("pulse without matching count step");

    cap_cycle_a: assert property (
        step_ff == flow_totalizer_pkg::ST_APPLY && applied_ff == 7'd120
        |=> step_ff == flow_totalizer_pkg::ST_IDLE && !inc_pulse_ff)
        else $error("more than 120 counts in one cycle");

    surplus_kept_a: assert property (
        step_ff == flow_totalizer_pkg::ST_APPLY && applied_ff == 7'd120
        && !clear_input_source |=> pend_ff == $past(pend_ff))
        else $error("surplus counts were dropped");

    clear_zero_a: assert property (clear_input_source [*2] |->
        digits == 32'h0 && pend_ff == '0 ##1 count_bcd_ff == 32'h0)
        else $error("count not held at zero under clear");

    sub_step_a: assert property (
        step_ff == flow_totalizer_pkg::ST_SUB && unit_fits && pend_ff != '1
        && !clear_input_source |=> acc_ff == $past(acc_ff)
        - ACC_W'($past(totalization_unit_setting_ff))
        && pend_ff == $past(pend_ff) + PEND_W'(1))
        else $error("unit not taken from the accumulator");

    // percent view must track the low digits shown on the count output
    percent_view_a: assert property ($stable(digits) [*2] |->
        count_percent_ff < 14'd10000
        && 4'(count_percent_ff % 14'd10) == count_bcd_ff[3:0]
        && 4'(count_percent_ff / 14'd1000) == count_bcd_ff[15:12])
        else $error("percent view out of range");

endmodule
`default_nettype wire

// *** logic/flow_totalizer_pkg.sv ***
// package: register map, reset values and timing counts of the totalizer
package flow_totalizer_pkg;

    // clock and processing cycle
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned CYCLE_TIME_MS  = 200;
    localparam int unsigned CYCLE_CLKS     = CYCLE_TIME_MS * CLK_MHZ * 1000;

    // fixed point: settings are unsigned 16.16
    localparam int unsigned FRAC_BITS      = 16;
    localparam int unsigned PCT_FULL       = 10000;  // 100.00 percent
    localparam int unsigned MAX_PER_CYCLE  = 120;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] STATUS_OFS      = 8'h04;
    localparam logic [7:0] UNIT_OFS        = 8'h08;
    localparam logic [7:0] FULL_FLOW_OFS   = 8'h0c;
    localparam logic [7:0] CYC_TIME_OFS    = 8'h10;
    localparam logic [7:0] CYC_LEN_OFS     = 8'h14;
    localparam logic [7:0] COUNT_OFS       = 8'h18;
    localparam logic [7:0] ACCUM_OFS       = 8'h1c;

    // field positions
    localparam int unsigned CTRL_ENABLE_BIT  = 0;
    localparam int unsigned STATUS_PEND_LSB  = 0;
    localparam int unsigned STATUS_STATE_LSB = 16;

    // reset values
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam logic [31:0] UNIT_RESET      = 32'h0001_0000;  // 1.0000
    localparam logic [31:0] FULL_FLOW_RESET = 32'h000a_0000;  // 10.000
    localparam logic [31:0] CYC_TIME_RESET  =
        32'((64'(CYCLE_TIME_MS) << FRAC_BITS) / 64'd1000);

    // processing sequence, gray coded
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ADD   = 2'b01,
        ST_SUB   = 2'b11,
        ST_APPLY = 2'b10
    } step_type;

endpackage

// *** testbench/flow_source_model.sv ***
// partner model: upstream blocks feeding flow percent and clear
`timescale 1ns/1ns
`default_nettype none
module flow_source_model (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // requests from the bench
    input  wire logic [15:0]  want_pct,
    input  wire logic         want_clr,
    // toward the totalizer
    output var  logic [15:0]  pct_ff,
    output var  logic         clr_ff
);
    // upstream outputs move once per edge, like a block output register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pct_ff <= 16'h0000;
            clr_ff <= 1'b0;
        end
        else
        begin
            pct_ff <= want_pct;
            clr_ff <= want_clr;
        end
    end
endmodule
`default_nettype wire

// *** testbench/flow_totalizer_test.sv ***
// self-checking bench for the flow totalizer with a behavioural model
`timescale 1ns/1ns
`default_nettype none
module flow_totalizer_test;
    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    localparam int unsigned CYC = 400;
    logic         pclk, presetn, psel, penable, pwrite, pready_ff, err;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata_ff, count_bcd_ff, rd;
    logic [15:0]  flow_input_source, want_pct;
    logic         clear_input_source, want_clr, inc_pulse_ff, pslverr_ff;
    logic [13:0]  count_percent_ff;
    longint       m_acc, m_pend, m_count, m_pct, fsf, unit, ct;
    int           bad_count, checks_done, pulses;

    flow_totalizer #(.CYCLE_CLKS(CYC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .flow_input_source(flow_input_source),
        .clear_input_source(clear_input_source),
        .inc_pulse_ff(inc_pulse_ff), .count_bcd_ff(count_bcd_ff),
        .count_percent_ff(count_percent_ff));

    flow_source_model src (
        .pclk(pclk), .presetn(presetn), .want_pct(want_pct),
        .want_clr(want_clr), .pct_ff(flow_input_source),
        .clr_ff(clear_input_source));

    // 250 MHz clock; pulse counter for per-tick comparison
    always #2 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (inc_pulse_ff === 1'b1)
            pulses++;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog may end this wait
        do
        begin
            @(posedge pclk);
        end
        while (pready_ff !== 1'b1);
        rd = prdata_ff;
        err = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] to_bcd(input longint v);
        logic [31:0] r;
        for (int i = 0; i < 8; i++)
        begin
            r[4*i +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction

    // reference integrator, pulse generator and capped counter
    task automatic model_tick(output longint n);
        m_acc = m_acc + fsf * m_pct * ct / 65536 / 10000;
        while (unit != 0 && m_acc >= unit)
        begin
            m_acc -= unit;
            if (m_pend < 65535)
                m_pend++;
        end
        n = (m_pend > 120) ? 120 : m_pend;
        m_pend -= n;
        m_count = (m_count + n) % 100000000;
    endtask

    // set flow for the next tick, follow it through status, compare
    // every add must reach one unit, else the short step may be missed
    task automatic run_tick(input int k);
        longint n;
        int     g;
        m_pct = 625 * k;
        want_pct <= 16'(m_pct);
        g = 0;
        do
        begin
            apb(1'b0, flow_totalizer_pkg::STATUS_OFS, 32'h0);
            g++;
        end
        while (rd[17:16] === 2'b00 && g < 300);
        while (rd[17:16] !== 2'b00 && g < 600)
        begin
            apb(1'b0, flow_totalizer_pkg::STATUS_OFS, 32'h0);
            g++;
        end
        repeat (4) @(posedge pclk);
        model_tick(n);
        check(32'(pulses), 32'(n));
        pulses = 0;
        check(count_bcd_ff, to_bcd(m_count));
        check(32'(count_percent_ff), 32'(m_count % 10000));
        apb(1'b0, flow_totalizer_pkg::COUNT_OFS, 32'h0);
        check(rd, to_bcd(m_count));
        apb(1'b0, flow_totalizer_pkg::STATUS_OFS, 32'h0);
        check(32'(rd[15:0]), 32'(m_pend));
        apb(1'b0, flow_totalizer_pkg::ACCUM_OFS, 32'h0);
        check(rd, 32'(m_acc));
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h290c));
        {pclk, presetn, psel, penable, pwrite, want_clr} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want_pct = 16'h0000;
        {bad_count, checks_done, pulses} = '0;
        {m_acc, m_pend, m_count, m_pct} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, flow_totalizer_pkg::UNIT_OFS, 32'h0);
        check(rd, flow_totalizer_pkg::UNIT_RESET);
        apb(1'b0, flow_totalizer_pkg::FULL_FLOW_OFS, 32'h0);
        check(rd, flow_totalizer_pkg::FULL_FLOW_RESET);
        apb(1'b0, 8'h20, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h0a, 32'h0003_0000);
        apb(1'b0, flow_totalizer_pkg::UNIT_OFS, 32'h0);
        check(rd, flow_totalizer_pkg::UNIT_RESET);
        apb(1'b1, flow_totalizer_pkg::COUNT_OFS, 32'h0000_1234);
        // whole-second cycle keeps every expected add exact
        fsf = 64'd16 << 16;
        unit = 64'h1_0000;
        ct = 64'h1_0000;
        apb(1'b1, flow_totalizer_pkg::CYC_LEN_OFS, 32'(CYC));
        apb(1'b1, flow_totalizer_pkg::CYC_TIME_OFS, 32'(ct));
        apb(1'b1, flow_totalizer_pkg::FULL_FLOW_OFS, 32'(fsf));
        run_tick(16);
        for (int p = 0; p < 2; p++)
        begin
            unit = p ? 64'h1_8000 : 64'h1_0000;
            apb(1'b1, flow_totalizer_pkg::UNIT_OFS, 32'(unit));
            for (int t = 0; t < 6; t++)
                run_tick(int'($urandom_range(16, 2)));
        end
        // overload on purpose: 200 units, 133 or 134 counts per cycle at unit 1.5, surplus must carry
        fsf = 64'd200 << 16;
        apb(1'b1, flow_totalizer_pkg::FULL_FLOW_OFS, 32'(fsf));
        for (int t = 0; t < 7; t++)
            run_tick(t < 3 ? 16 : 1);
        apb(1'b1, flow_totalizer_pkg::CTRL_OFS, 32'h0);
        want_clr <= 1'b1;
        repeat (450) @(posedge pclk);
        check(count_bcd_ff, 32'h0);
        check(32'(pulses), 32'h0);
        want_clr <= 1'b0;
        repeat (4) @(posedge pclk);
        {m_acc, m_pend, m_count} = '0;
        apb(1'b1, flow_totalizer_pkg::CTRL_OFS, 32'h1);
        run_tick(8);
        run_tick(12);
        report_and_stop();
    end

    // cut a hang short well beyond the expected run
    initial
    begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
